/* File: rtl/bom_cfg.svh */
// Register offsets, field positions, reset values and threshold arithmetic for the brownout monitor
`ifndef BOM_CFG_SVH
`define BOM_CFG_SVH
// Register byte offsets
`define BOM_OFS_CTRL 8'h00
`define BOM_OFS_RAILTH 8'h04
`define BOM_OFS_BATTTH 8'h08
`define BOM_OFS_SUPTH 8'h0c
`define BOM_OFS_STATUS 8'h10
`define BOM_OFS_MASK 8'h14
`define BOM_OFS_LIVE 8'h18
// Control fields
`define BOM_CTRL_MASTER 5
`define BOM_CTRL_EN_LSB 0
// Status bit positions
`define BOM_EV_CORE 0
`define BOM_EV_ANA 1
`define BOM_EV_IO 2
`define BOM_EV_MEM 3
`define BOM_EV_BATT 4
`define BOM_EV_DROOP 5
`define BOM_EV_INTER 6
`define BOM_EV_VALID 7
// Threshold arithmetic in millivolts
`define BOM_RAIL_STEP_MV 25
`define BOM_BATT_BASE_MV 2400
`define BOM_BATT_STEP_MV 40
`define BOM_INTER_BASE_MV 3600
`define BOM_INTER_STEP_MV 25
`define BOM_HYST_MV 50
// Reset values
`define BOM_RST_CTRL 6'h00
`define BOM_RST_RAILTH 32'h0000_0000
`define BOM_RST_BATTTH 5'h14
`define BOM_RST_SUPTH 7'h00
`endif

/* File: rtl/bom_pkg.sv */
// Types shared by the brownout monitor files
package bom_pkg;
  // Detector index in the event vector
  typedef enum logic [2:0] {
    BOM_DET_CORE = 3'b000,
    BOM_DET_ANA = 3'b001,
    BOM_DET_IO = 3'b010,
    BOM_DET_MEM = 3'b011,
    BOM_DET_BATT = 3'b100
  } bom_det_e;
  // Measured levels from the analog front end, in millivolts
  typedef struct packed {
    logic [12:0] core_mv;
    logic [12:0] ana_mv;
    logic [12:0] io_mv;
    logic [12:0] mem_mv;
    logic [12:0] batt_mv;
    logic [12:0] five_mv;
    logic [12:0] inter_mv;
  } bom_level_s;
  // Rail target voltages, in millivolts
  typedef struct packed {
    logic [12:0] core_mv;
    logic [12:0] ana_mv;
    logic [12:0] io_mv;
    logic [12:0] mem_mv;
  } bom_target_s;
  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } bom_wb_req_s;
  typedef logic [12:0] bom_mv_t;
endpackage

/* File: rtl/bom_sync.sv */
// Two flip-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module bom_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] q_q; // Second stage
  // Two stages; nothing reads the first one except the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q_q <= '0;
    end else begin
      meta_q <= d;
      q_q <= meta_q;
    end
  end
  assign q = q_q;
endmodule

/* File: rtl/bom_cmp.sv */
// Under-threshold comparator with optional hysteresis
`timescale 1ns/1ps
`include "bom_cfg.svh"
module bom_cmp import bom_pkg::*; #(
  parameter bit HYST = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Level and threshold
  input wire bom_mv_t level,
  input wire bom_mv_t thresh,
  // Result
  output logic below
);
  logic below_q; // Held indication
  logic below_d;
  logic [13:0] rel; // Release level
  // Trip below threshold; release only at or above threshold plus hysteresis
  always_comb begin
    rel = {1'b0, thresh} + (HYST ? 14'(`BOM_HYST_MV) : 14'h0000);
    below_d = below_q;
    if ({1'b0, level} < {1'b0, thresh}) begin
      below_d = 1'b1;
    end else if ({1'b0, level} >= rel) begin
      below_d = 1'b0;
    end
  end
  // Register the indication
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      below_q <= 1'b0;
    end else begin
      below_q <= below_d;
    end
  end
  assign below = below_q;
endmodule

/* File: rtl/bom_top.sv */
// Brownout monitor with interrupts and automatic shutdown
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "bom_cfg.svh"
module bom_top import bom_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog front end (asynchronous)
  input wire bom_level_s level_i,
  input wire bom_target_s target_i,
  input wire logic five_volt_present_i,
  // Outputs
  output logic fast_interrupt_request_o,
  output logic power_down_o
);
  // Synchronised pins
  bom_level_s lvl;
  bom_target_s tgt;
  logic present;
  bom_sync #(.W($bits(bom_level_s))) u_sync_lvl (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(level_i),
    .q(lvl)
  );
  bom_sync #(.W($bits(bom_target_s) + 1)) u_sync_tgt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({target_i, five_volt_present_i}),
    .q({tgt, present})
  );

  // Software registers
  logic [5:0] ctrl_q, ctrl_d; // Enables [4:0] and master
  logic [31:0] railth_q, railth_d; // Four 3-bit margins, bytes 0..3
  logic [4:0] battth_q, battth_d; // Battery step count
  logic [6:0] supth_q, supth_d; // [1:0] droop sel, [6:2] intermediate steps
  logic [7:0] stat_q, stat_d; // Sticky events
  logic [7:0] mask_q, mask_d; // Interrupt mask
  logic valid_seen_q, valid_seen_d; // Five-volt has risen above valid once
  logic [31:0] rdat_q, rdat_d;
  logic ack_q, ack_d;
  logic irq_q, irq_d;
  logic pd_q, pd_d;

  // Threshold computation
  bom_mv_t th_core, th_ana, th_io, th_mem, th_batt, th_droop, th_inter;
  bom_mv_t th_valid;
  logic [7:0] below; // Comparator results in status layout
  logic [2:0] m_core, m_ana, m_io, m_mem;
  // Margin in mV for a 3-bit field, 0..175
  function automatic bom_mv_t margin(input logic [2:0] s);
    margin = 13'(s) * 13'(`BOM_RAIL_STEP_MV);
  endfunction
  // Rail thresholds are target less a margin; battery and intermediate absolute
  always_comb begin
    m_core = railth_q[2:0];
    m_ana = railth_q[10:8];
    m_io = railth_q[18:16];
    m_mem = railth_q[26:24];
    th_core = tgt.core_mv - margin(m_core);
    th_ana = tgt.ana_mv - margin(m_ana);
    th_io = tgt.io_mv - margin(m_io);
    th_mem = tgt.mem_mv - margin(m_mem);
    th_batt = 13'(`BOM_BATT_BASE_MV) + 13'(battth_q) * 13'(`BOM_BATT_STEP_MV);
    th_inter = 13'(`BOM_INTER_BASE_MV) + 13'(supth_q[6:2]) * 13'(`BOM_INTER_STEP_MV);
    // Four droop levels; encoding chosen locally
    unique case (supth_q[1:0])
      2'h0: th_droop = 13'd4300;
      2'h1: th_droop = 13'd4400;
      2'h2: th_droop = 13'd4500;
      2'h3: th_droop = 13'd4700;
    endcase
    th_valid = 13'd4400; // Supply-valid level, fixed by the front end
  end

  // Comparators; droop gets hysteresis so its indication does not chatter
  bom_cmp #(.HYST(1'b0)) u_c_core (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.core_mv), .thresh(th_core), .below(below[`BOM_EV_CORE]));
  bom_cmp #(.HYST(1'b0)) u_c_ana (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.ana_mv), .thresh(th_ana), .below(below[`BOM_EV_ANA]));
  bom_cmp #(.HYST(1'b0)) u_c_io (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.io_mv), .thresh(th_io), .below(below[`BOM_EV_IO]));
  bom_cmp #(.HYST(1'b0)) u_c_mem (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.mem_mv), .thresh(th_mem), .below(below[`BOM_EV_MEM]));
  bom_cmp #(.HYST(1'b0)) u_c_batt (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.batt_mv), .thresh(th_batt), .below(below[`BOM_EV_BATT]));
  bom_cmp #(.HYST(1'b1)) u_c_droop (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.five_mv), .thresh(th_droop), .below(below[`BOM_EV_DROOP]));
  bom_cmp #(.HYST(1'b0)) u_c_inter (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.inter_mv), .thresh(th_inter), .below(below[`BOM_EV_INTER]));
  bom_cmp #(.HYST(1'b0)) u_c_valid (.clk_sys(clk_sys), .rst_n(rst_n),
    .level(lvl.five_mv), .thresh(th_valid), .below(below[`BOM_EV_VALID]));

  // Bus decode
  logic req, wr, rd;
  logic [7:0] ev_prev_q, ev_prev_d; // Previous comparator state for edge detect
  logic [7:0] rise;
  logic [1:0] warm_q, warm_d; // Cycles since reset, saturates at 3
  logic warm_done; // Synchronisers hold real pin levels
  logic [4:0] auto_src; // Shutdown candidates: core, ana, io, batt, five
  // Register file, sticky status and shutdown next-state
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_q;
    wr = req && wb_we_i;
    rd = req && !wb_we_i;
    ctrl_d = ctrl_q;
    railth_d = railth_q;
    battth_d = battth_q;
    supth_d = supth_q;
    mask_d = mask_q;
    rdat_d = rdat_q;
    ack_d = req;
    // Synchronisers read zero right after reset, which looks like a brownout;
    // ignore edges until real levels reach the comparators, then catch any
    // detector that is still below so a genuine low supply is not lost
    warm_done = (warm_q == 2'h3);
    warm_d = warm_done ? warm_q : warm_q + 2'h1;
    ev_prev_d = warm_done ? below : 8'h00;
    rise = warm_done ? (below & ~ev_prev_q) : 8'h00;
    stat_d = stat_q;
    // Writes honour byte lanes; unmapped offsets are ignored
    if (wr) begin
      unique case (wb_adr_i)
        `BOM_OFS_CTRL: if (wb_sel_i[0]) ctrl_d = wb_dat_i[5:0];
        `BOM_OFS_RAILTH: begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) railth_d[b*8 +: 8] = {5'h00, wb_dat_i[b*8 +: 3]};
          end
        end
        `BOM_OFS_BATTTH: if (wb_sel_i[0]) battth_d = wb_dat_i[4:0];
        `BOM_OFS_SUPTH: if (wb_sel_i[0]) supth_d = wb_dat_i[6:0];
        `BOM_OFS_MASK: if (wb_sel_i[0]) mask_d = wb_dat_i[7:0];
        default: ;
      endcase
    end
    // Reads return data; status read clears it; unmapped reads zero
    if (rd) begin
      unique case (wb_adr_i)
        `BOM_OFS_CTRL: rdat_d = {26'h0, ctrl_q};
        `BOM_OFS_RAILTH: rdat_d = railth_q;
        `BOM_OFS_BATTTH: rdat_d = {27'h0, battth_q};
        `BOM_OFS_SUPTH: rdat_d = {25'h0, supth_q};
        `BOM_OFS_STATUS: begin
          rdat_d = {24'h0, stat_q};
          stat_d = 8'h00;
        end
        `BOM_OFS_MASK: rdat_d = {24'h0, mask_q};
        `BOM_OFS_LIVE: rdat_d = {23'h0, valid_seen_q, below};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    // New trips set after the clear so a same-cycle event survives
    stat_d = stat_d | rise;
    // Interrupt from any unmasked sticky bit, with or without five-volt
    irq_d = |(stat_d & mask_q);
    // Arm five-volt shutdown only after the input was once valid
    valid_seen_d = valid_seen_q | (present && !below[`BOM_EV_VALID]);
    // Core, analog and IO rails and battery only while five-volt absent; memory rail and droop never listed
    auto_src[0] = below[`BOM_EV_CORE] && !present;
    auto_src[1] = below[`BOM_EV_ANA] && !present;
    auto_src[2] = below[`BOM_EV_IO] && !present;
    auto_src[3] = below[`BOM_EV_BATT] && !present;
    auto_src[4] = below[`BOM_EV_VALID] && valid_seen_q;
    // Local enables gated by master; power-down holds until reset
    pd_d = pd_q | (ctrl_q[`BOM_CTRL_MASTER] && |(auto_src & ctrl_q[4:0]));
  end

  // Register all state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `BOM_RST_CTRL;
      railth_q <= `BOM_RST_RAILTH;
      battth_q <= `BOM_RST_BATTTH;
      supth_q <= `BOM_RST_SUPTH;
      stat_q <= 8'h00;
      mask_q <= 8'h00;
      valid_seen_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      irq_q <= 1'b0;
      pd_q <= 1'b0;
      ev_prev_q <= 8'h00;
      warm_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      railth_q <= railth_d;
      battth_q <= battth_d;
      supth_q <= supth_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      valid_seen_q <= valid_seen_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
      irq_q <= irq_d;
      pd_q <= pd_d;
      ev_prev_q <= ev_prev_d;
      warm_q <= warm_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign fast_interrupt_request_o = irq_q;
  assign power_down_o = pd_q;
endmodule

/* File: bench/bom_properties.sv */
// Checker for bus timing, shutdown and interrupt release of the monitor
`timescale 1ns/1ps
module bom_top_checker import bom_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Supplies and outputs
  input wire bom_level_s level_i,
  input wire logic five_volt_present_i,
  input wire logic fast_interrupt_request_o,
  input wire logic power_down_o
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Request held by the master
  logic req;
  assign req = wb_cyc_i && wb_stb_i;
  ack_one_cycle_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  // Read data only moves on a read
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> $past(req && !wb_we_i))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18 |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  shutdown_sticky_a: assert property (power_down_o |=> power_down_o)
    else $error("shutdown dropped");
  // Rail trips may not power down while five-volt input is there
  present_five_only_a: assert property (
    $rose(power_down_o) && five_volt_present_i |-> level_i.five_mv < 13'd4400)
    else $error("shutdown while five-volt input valid");
  irq_release_a: assert property (
    $fell(fast_interrupt_request_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("interrupt dropped without access");
  cover property ($rose(power_down_o));
  cover property ($rose(fast_interrupt_request_o));
  cover property (wb_ack_o && !wb_we_i);
endmodule
bind bom_top bom_top_checker i_chk (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .level_i, .five_volt_present_i, .fast_interrupt_request_o, .power_down_o);

/* File: bench/bom_rails_model.sv */
// Supply model: rail targets, measured levels and five-volt presence
`timescale 1ns/1ps
module bom_rails_model import bom_pkg::*; (
  // Levels seen by the monitor
  output bom_level_s level_o,
  output bom_target_s target_o,
  output logic present_o
);
  // Healthy supplies at time zero; the bench moves them later
  initial begin
    target_o = {13'd1200, 13'd1800, 13'd3300, 13'd1500};
    level_o = {13'd1200, 13'd1800, 13'd3300, 13'd1500, 13'd3600, 13'd5000, 13'd4200};
    present_o = 1'b0;
  end
endmodule

/* File: bench/bom_top_tb.sv */
// Testbench for the brownout monitor
`timescale 1ns/1ps
module bom_top_tb import bom_pkg::*; ;
  logic clk_sys, rst_n, cyc, stb, we, ack, irq, pdn, pres;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat_o, rdat;
  bom_level_s lvl;
  bom_target_s tgt;
  int bad_count, total_checks;
  bom_rails_model i_model (.level_o(lvl), .target_o(tgt), .present_o(pres));
  bom_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .level_i(lvl), .target_i(tgt), .five_volt_present_i(pres),
    .fast_interrupt_request_o(irq), .power_down_o(pdn));
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Classic cycle, held until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    if (n >= 20) begin
      bad_count++;
      test_done();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat & m, e, "read");
  endtask
  // Sync, compare, edge and interrupt stages fit in twelve cycles
  task automatic settle();
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  // Watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
  initial begin
    int thr[4] = '{4300, 4400, 4500, 4700};
    {cyc, stb, we, adr, sel, wdat, rst_n, bad_count, total_checks} = '0;
    reset();
    rdchk(8'h08, '1, 32'h14);
    rdchk(8'h1c, '1, 32'h0);
    // Core margin four steps, interrupt masked
    bus(1'b1, 8'h04, 32'h4);
    i_model.level_o.core_mv <= 13'd1100;
    settle();
    rdchk(8'h10, '1, 32'h0);
    i_model.level_o.core_mv <= 13'd1099;
    settle();
    chk(irq, 32'h0, "masked irq");
    rdchk(8'h10, 32'h1, 32'h1);
    bus(1'b1, 8'h14, 32'hff);
    bus(1'b1, 8'h08, 32'd20);
    i_model.level_o.batt_mv <= 13'd3200;
    settle();
    rdchk(8'h10, '1, 32'h0);
    i_model.level_o.batt_mv <= 13'd3199;
    settle();
    chk(irq, 32'h1, "batt irq");
    rdchk(8'h10, '1, 32'h10);
    settle();
    chk(irq, 32'h0, "irq cleared");
    // Intermediate rail at step 4
    bus(1'b1, 8'h0c, 32'h10);
    i_model.level_o.inter_mv <= 13'd3699;
    settle();
    rdchk(8'h10, 32'h40, 32'h40);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h0c, 32'h10 | i);
      i_model.level_o.five_mv <= 13'(thr[i]);
      settle();
      rdchk(8'h10, 32'h20, 32'h0);
      i_model.level_o.five_mv <= 13'(thr[i] - 1);
      settle();
      rdchk(8'h10, 32'h20, 32'h20);
      i_model.level_o.five_mv <= 13'(thr[i] + 49);
      settle();
      i_model.level_o.five_mv <= 13'(thr[i] - 1);
      settle();
      rdchk(8'h10, 32'h20, 32'h0);
      i_model.level_o.five_mv <= 13'd5000;
      settle();
    end
    // Five-volt present: rail and battery trips stay harmless
    i_model.present_o <= 1'b1;
    settle();
    bus(1'b1, 8'h00, 32'h3f);
    settle();
    chk(pdn, 32'h0, "rail shutdown");
    bus(1'b1, 8'h0c, 32'h13);
    i_model.level_o.five_mv <= 13'd4600;
    settle();
    chk(pdn, 32'h0, "droop shutdown");
    i_model.level_o.five_mv <= 13'd4399;
    settle();
    chk(pdn, 32'h1, "valid shutdown");
    // Second life: five-volt never valid, then battery only
    i_model.level_o <= {13'd1200, 13'd1800, 13'd3300, 13'd1400, 13'd3600, 13'd4000, 13'd4200};
    reset();
    bus(1'b1, 8'h00, 32'h3f);
    settle();
    chk(pdn, 32'h0, "not armed");
    i_model.present_o <= 1'b0;
    settle();
    chk(pdn, 32'h0, "memory rail");
    rdchk(8'h10, 32'h8, 32'h8);
    bus(1'b1, 8'h00, 32'h1f);
    i_model.level_o.batt_mv <= 13'd3000;
    settle();
    chk(pdn, 32'h0, "no master");
    i_model.level_o.batt_mv <= 13'd3600;
    bus(1'b1, 8'h00, 32'h28);
    settle();
    i_model.level_o.batt_mv <= 13'd3000;
    settle();
    chk(pdn, 32'h1, "batt shutdown");
    test_done();
  end
endmodule
